// File: uoc_consts.vh
// Purpose: Constants for the USB OTG line, VBUS boost and descriptor table control block
// Assumes: Included by uoc_line_ctrl.v, not by uoc_boost_pwm.v
// Notes:   Bit positions are within each 16-bit control word
`ifndef UOC_CONSTS_VH
`define UOC_CONSTS_VH

// ----------------------------------------------------------------
// Usb control register bits
// ----------------------------------------------------------------
`define UOC_CON_MODULE_ENABLE   0
`define UOC_CON_HOST_ENABLE     3

// ----------------------------------------------------------------
// Otg control register bits
// ----------------------------------------------------------------
`define UOC_OTG_VBUS_DISCHARGE  0
`define UOC_OTG_VBUS_TARGET     1
`define UOC_OTG_LINE_CTRL_EN    2
`define UOC_OTG_VBUS_GEN_EN     3
`define UOC_OTG_DM_PULLDOWN     4
`define UOC_OTG_DP_PULLDOWN     5
`define UOC_OTG_DP_PULLUP       7

// ----------------------------------------------------------------
// Module power register bit
// ----------------------------------------------------------------
`define UOC_PWR_MODULE_POWER    0

// ----------------------------------------------------------------
// Boost pwm control and period/duty fields
// ----------------------------------------------------------------
`define UOC_PWM_COUNTER_ENABLE  8
`define UOC_PWM_POLARITY        9
`define UOC_PWM_MODULE_ENABLE   15
`define UOC_PWM_PERIOD_LSB      0
`define UOC_PWM_DUTY_LSB        8

// ----------------------------------------------------------------
// Ping-pong modes of the usb config register
// ----------------------------------------------------------------
`define UOC_PP_NONE             2'h0
`define UOC_PP_EP0_OUT          2'h1
`define UOC_PP_ALL              2'h2
`define UOC_PP_ALL_BUT_EP0      2'h3

// ----------------------------------------------------------------
// Descriptor table geometry
// ----------------------------------------------------------------
`define UOC_BD_COUNT            64
`define UOC_BD_BYTES            4
`define UOC_BD_ADDR_WORD_OFS    2'h2
`define UOC_BD_STAT_WORD_OFS    2'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UOC_RST_ZERO16          16'h0000

`endif

// File: uoc_boost_pwm.v
// Purpose: Boost-assist PWM with period/duty byte fields and polarity select
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Output is held low while module is disabled, and at the polarity level while only the counter is disabled
module uoc_boost_pwm #(
    parameter CNT_W = 8
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             counter_enable,
    input  wire             module_enable,
    input  wire             polarity,
    input  wire [CNT_W-1:0] period,
    input  wire [CNT_W-1:0] duty,
    output reg              pwm_out
);

    reg  [CNT_W-1:0] count_q;
    wire             active;

    // ------------------------------------------------------------
    // Period counter, wraps at the programmed period
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= {CNT_W{1'b0}};
        end else if (!counter_enable || count_q >= period) begin
            count_q <= {CNT_W{1'b0}};
        end else begin
            count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Active phase while count below duty
    assign active = counter_enable && module_enable && (count_q < duty);

    // ------------------------------------------------------------
    // Registered output with selectable polarity
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_out <= 1'b0;
        end else if (!module_enable) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= active ^ polarity;
        end
    end

endmodule // uoc_boost_pwm

// File: uoc_line_ctrl.v
// Purpose: USB OTG data-line pull control, VBUS boost sequencing and descriptor table addressing
// Assumes: Control words arrive as plain ports; 25 MHz clock; async active-low reset
// Notes:   Packet engine is outside; it asks for descriptor addresses and reports endpoints
`include "uoc_consts.vh"

// Overview of operation
// - Device role, line control off: D+ pull-up follows the module enable bit.
// - Line control on: D+ pull-up follows its own bit in the OTG control word.
// - Line control off: host enable connects both D+ and D- pull-downs.
// - Line control on: D+ and D- pull-downs follow their own two bits.
// - Boost period comes from low byte, duty from high byte.
// - One PWM control bit selects boost output polarity.
// - One OTG control bit selects between two target VBUS voltages.
// - Boost PWM drives external 5V supply; comparators watch voltage and current.
// - Table sits on 256-byte boundary; pointer holds upper address byte.
// - Each descriptor is two 16-bit words; indices 0 to 63.
// - Buffer address word is 16 bits, so DMA reaches first 64 Kbytes.
// - Descriptor chosen from endpoint, direction and two-bit ping-pong mode.
// - Host role uses only endpoint zero descriptors and control register.
// - Host role reports received packet's source endpoint in status field.
// - Host role transmit endpoint comes from the token register value.
// - Pull-up stays connected while the bus is suspended.
// - Owner flag set means module owns descriptor; CPU must not modify it.
// - No ping-pong maps 2n/2n+1; full ping-pong maps 4n..4n+3.
module uoc_line_ctrl #(
    parameter PWM_W = 8
) (
    input  wire        clk,
    input  wire        reset_n,
    // Control words written by software
    input  wire [15:0] usb_control_register,
    input  wire [15:0] otg_control_register,
    input  wire [15:0] module_power_register,
    input  wire [15:0] boost_period_duty_register,
    input  wire [15:0] boost_pwm_control_register,
    input  wire [7:0]  descriptor_table_pointer,
    input  wire [1:0]  usb_config_register,
    input  wire [15:0] endpoint_zero_control_register,
    input  wire [3:0]  token_register,
    // Bus state and comparators
    input  wire        bus_suspended,
    input  wire        vbus_above_target,
    input  wire        boost_over_current,
    // Descriptor request from the packet engine
    input  wire        bd_req,
    input  wire [3:0]  bd_endpoint,
    input  wire        bd_tx,
    input  wire        bd_odd,
    input  wire        bd_addr_word,
    // Received-packet report from the packet engine
    input  wire        rx_done,
    input  wire [3:0]  rx_remote_endpoint,
    // Descriptor status word read back from RAM
    input  wire        bd_stat_valid,
    input  wire [15:0] bd_stat_data,
    // Pin controls
    output reg         dplus_pullup_en,
    output reg         dplus_pulldown_en,
    output reg         dminus_pulldown_en,
    output reg         boost_pwm_out,
    output reg         vbus_gen_active,
    output reg         vbus_target_sel,
    // Descriptor access
    output reg         bd_ack,
    output reg  [5:0]  bd_index,
    output reg  [15:0] bd_ram_addr,
    output reg  [15:0] ep_control_used,
    output reg  [3:0]  tx_remote_endpoint,
    output reg  [3:0]  last_endpoint_field,
    output reg         descriptor_owner_flag
);

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    wire module_enable_bit       = usb_control_register[`UOC_CON_MODULE_ENABLE];
    wire host_role_enable        = usb_control_register[`UOC_CON_HOST_ENABLE];
    wire otg_line_control_enable = otg_control_register[`UOC_OTG_LINE_CTRL_EN];
    wire dplus_pullup_bit        = otg_control_register[`UOC_OTG_DP_PULLUP];
    wire dplus_pulldown_bit      = otg_control_register[`UOC_OTG_DP_PULLDOWN];
    wire dminus_pulldown_bit     = otg_control_register[`UOC_OTG_DM_PULLDOWN];
    wire vbus_target_select      = otg_control_register[`UOC_OTG_VBUS_TARGET];
    wire vbus_gen_enable         = otg_control_register[`UOC_OTG_VBUS_GEN_EN];
    wire vbus_discharge          = otg_control_register[`UOC_OTG_VBUS_DISCHARGE];
    wire module_power            = module_power_register[`UOC_PWR_MODULE_POWER];
    wire boost_counter_enable    = boost_pwm_control_register[`UOC_PWM_COUNTER_ENABLE];
    wire boost_pwm_enable        = boost_pwm_control_register[`UOC_PWM_MODULE_ENABLE];
    wire boost_output_polarity   = boost_pwm_control_register[`UOC_PWM_POLARITY];

    wire [PWM_W-1:0] boost_period;
    wire [PWM_W-1:0] boost_duty;
    wire             pwm_raw;
    wire             gen_ok;

    // Period from low byte, duty from high byte
    assign boost_period = boost_period_duty_register[`UOC_PWM_PERIOD_LSB +: PWM_W];
    assign boost_duty   = boost_period_duty_register[`UOC_PWM_DUTY_LSB +: PWM_W];

    // ------------------------------------------------------------
    // Boost PWM generator
    // ------------------------------------------------------------
    uoc_boost_pwm #(
        .CNT_W          (PWM_W)
    ) u_pwm (
        .clk            (clk),
        .reset_n        (reset_n),
        .counter_enable (boost_counter_enable),
        .module_enable  (boost_pwm_enable),
        .polarity       (boost_output_polarity),
        .period         (boost_period),
        .duty           (boost_duty),
        .pwm_out        (pwm_raw)
    );

    // Generation runs only with generation enabled, power on, no discharge, and PWM module and counter enabled
    assign gen_ok = vbus_gen_enable && module_power && !vbus_discharge
                    && boost_pwm_enable && boost_counter_enable;

    // ------------------------------------------------------------
    // Pull resistor selection
    // ------------------------------------------------------------
    reg pu_d;
    reg dp_pd_d;
    reg dm_pd_d;

    always @* begin
        if (otg_line_control_enable) begin
            pu_d    = dplus_pullup_bit;
            dp_pd_d = dplus_pulldown_bit;
            dm_pd_d = dminus_pulldown_bit;
        end else begin
            pu_d    = module_enable_bit && !host_role_enable;
            dp_pd_d = host_role_enable;
            dm_pd_d = host_role_enable;
        end
    end

    // ------------------------------------------------------------
    // Registered line and boost outputs; suspend does not alter pulls
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dplus_pullup_en    <= 1'b0;
            dplus_pulldown_en  <= 1'b0;
            dminus_pulldown_en <= 1'b0;
            boost_pwm_out      <= 1'b0;
            vbus_gen_active    <= 1'b0;
            vbus_target_sel    <= 1'b0;
        end else begin
            dplus_pullup_en    <= pu_d;
            dplus_pulldown_en  <= dp_pd_d;
            dminus_pulldown_en <= dm_pd_d;
            vbus_target_sel    <= vbus_target_select;
            vbus_gen_active    <= gen_ok;
            // Stop switching once output reaches target or current limit trips
            boost_pwm_out      <= gen_ok && pwm_raw && !vbus_above_target
                                  && !boost_over_current;
        end
    end

    // ------------------------------------------------------------
    // Descriptor index mapping
    // ------------------------------------------------------------
    reg [5:0] idx_d;
    reg [3:0] ep_eff;
    reg [4:0] ep_x2;

    always @* begin
        ep_eff = host_role_enable ? 4'h0 : bd_endpoint;
        ep_x2  = {ep_eff, 1'b0};
        case (usb_config_register)
            `UOC_PP_NONE: begin
                idx_d = {1'b0, ep_x2} + {5'h00, bd_tx};
            end
            `UOC_PP_EP0_OUT: begin
                if (ep_eff == 4'h0 && !bd_tx) begin
                    idx_d = {5'h00, bd_odd};
                end else begin
                    idx_d = {1'b0, ep_x2} + {5'h00, bd_tx} + 6'h01;
                end
            end
            `UOC_PP_ALL: begin
                idx_d = {ep_eff, bd_tx, bd_odd};
            end
            `UOC_PP_ALL_BUT_EP0: begin
                if (ep_eff == 4'h0) begin
                    idx_d = {5'h00, bd_tx};
                end else begin
                    idx_d = {ep_eff, bd_tx, bd_odd} - 6'h02;
                end
            end
            default: begin
                idx_d = 6'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Descriptor address, endpoint reporting and owner capture
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bd_ack                <= 1'b0;
            bd_index              <= 6'h00;
            bd_ram_addr           <= `UOC_RST_ZERO16;
            ep_control_used       <= `UOC_RST_ZERO16;
            tx_remote_endpoint    <= 4'h0;
            last_endpoint_field   <= 4'h0;
            descriptor_owner_flag <= 1'b0;
        end else begin
            bd_ack <= bd_req;
            if (bd_req) begin
                bd_index <= idx_d;
                // Pointer byte is the upper address byte, index times four below it
                bd_ram_addr <= {descriptor_table_pointer, idx_d,
                                (bd_addr_word ? `UOC_BD_ADDR_WORD_OFS : `UOC_BD_STAT_WORD_OFS)};
                if (host_role_enable) begin
                    ep_control_used    <= endpoint_zero_control_register;
                    tx_remote_endpoint <= token_register;
                end
            end
            if (rx_done && host_role_enable) begin
                last_endpoint_field <= rx_remote_endpoint;
            end
            if (bd_stat_valid) begin
                descriptor_owner_flag <= bd_stat_data[15];
            end
        end
    end

endmodule // uoc_line_ctrl

// File: uoc_line_ctrl_asserts.sv
// Purpose: Checks the line, boost and descriptor ports over time
// Assumes: Bound to uoc_line_ctrl; one clock, async active-low reset
// Notes:   One cycle latency on lines and answers, two on the pwm
module uoc_line_ctrl_asserts #(
    parameter PWM_W = 8
) (
    input wire        clk, reset_n, bd_req, bd_addr_word, rx_done, bd_stat_valid,
    input wire [15:0] usb_control_register, otg_control_register, boost_pwm_control_register,
    input wire [15:0] endpoint_zero_control_register, bd_stat_data, bd_ram_addr, ep_control_used,
    input wire [7:0]  descriptor_table_pointer,
    input wire [3:0]  token_register, rx_remote_endpoint, tx_remote_endpoint, last_endpoint_field,
    input wire [5:0]  bd_index,
    input wire        dplus_pullup_en, dplus_pulldown_en, dminus_pulldown_en, boost_pwm_out,
    input wire        vbus_gen_active, vbus_target_sel, bd_ack, descriptor_owner_flag,
    input wire        vbus_above_target, boost_over_current
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire [15:0] usb = usb_control_register;
    wire [15:0] otg = otg_control_register;
    wire [15:0] pwc = boost_pwm_control_register;
    // ----------------------------------------------------------------
    // Descriptor request and answer
    // ----------------------------------------------------------------
    sequence s_req;
        bd_req;
    endsequence
    sequence s_answer;
        bd_ack && bd_ram_addr == {$past(descriptor_table_pointer), bd_index, $past(bd_addr_word), 1'b0};
    endsequence
    a_desc_answer: assert property (s_req |=> s_answer)
        else $error("descriptor answer wrong");
    a_ack_only_req: assert property (!bd_req |=> !bd_ack)
        else $error("acknowledge without request");
    a_host_ep_zero: assert property (bd_req && usb[3] |=> bd_index < 6'h04 && ep_control_used ==
        $past(endpoint_zero_control_register) && tx_remote_endpoint == $past(token_register))
        else $error("host transfer off endpoint zero");
    a_host_rx_ep: assert property (rx_done && usb[3] |=> last_endpoint_field == $past(rx_remote_endpoint))
        else $error("source endpoint not reported");
    a_owner_flag: assert property (bd_stat_valid |=> descriptor_owner_flag == $past(bd_stat_data[15]))
        else $error("owner flag not captured");
    // ----------------------------------------------------------------
    // Line pulls and boost
    // ----------------------------------------------------------------
    a_pullup_module: assert property (!otg[2] |=> dplus_pullup_en == $past(usb[0] & ~usb[3]))
        else $error("pull-up does not follow module enable");
    a_pullup_otg: assert property (otg[2] |=> dplus_pullup_en == $past(otg[7]))
        else $error("pull-up does not follow its own bit");
    a_pulldown_host: assert property (!otg[2] |=> {dplus_pulldown_en, dminus_pulldown_en} == {2{$past(usb[3])}})
        else $error("pull-downs do not follow host enable");
    a_pulldown_otg: assert property (otg[2] |=> {dplus_pulldown_en, dminus_pulldown_en} == $past(otg[5:4]))
        else $error("pull-downs do not follow their bits");
    a_target_sel: assert property (1'b1 |=> vbus_target_sel == $past(otg[1]))
        else $error("target select not copied");
    a_gen_gated: assert property (otg[0] || !otg[3] |=> !vbus_gen_active)
        else $error("generation active while gated");
    a_pwm_off: assert property ((!pwc[8] || !pwc[15])[*2] |=> !boost_pwm_out)
        else $error("pwm drives while disabled");
    a_pwm_comp_gate: assert property (vbus_above_target || boost_over_current |=> !boost_pwm_out)
        else $error("pwm drives past target or limit");
endmodule // uoc_line_ctrl_asserts

// File: uoc_far_model.sv
// Purpose: Far-side model answering descriptor status-word reads
// Assumes: Same clock; answers the cycle after bd_ack
// Notes:   Owner bit follows address bit 2, so neighbouring slots differ
module uoc_far_model (
    input  wire         clk, reset_n, bd_ack,
    input  wire  [15:0] bd_ram_addr,
    output logic        bd_stat_valid,
    output logic [15:0] bd_stat_data
);
    // Status word comes back only for status-word addresses
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bd_stat_valid <= 1'b0;
            bd_stat_data  <= 16'hA5A5;
        end else if (bd_ack && bd_ram_addr[1] == 1'b0) begin
            bd_stat_valid <= 1'b1;
            bd_stat_data  <= {bd_ram_addr[2], 5'h00, bd_ram_addr[9:0]};
        end else begin
            bd_stat_valid <= 1'b0;
            bd_stat_data  <= ~bd_stat_data; // Released data never holds
        end
    end
endmodule // uoc_far_model

// File: tb_top.sv
// Purpose: Self-checking bench for uoc_line_ctrl
// Assumes: 25 MHz clock; inputs change 1 ns after the rising edge
// Notes:   Descriptor mapping runs from a row table; the rest by hand
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] m; logic [3:0] ep; logic tx; logic odd; logic host; logic [5:0] idx;} uoc_row_t;
    logic        clk, reset_n, bd_req, bd_tx, bd_odd, bd_addr_word, rx_done, bus_suspended;
    logic        vbus_above_target, boost_over_current;
    logic [15:0] usb_control_register, otg_control_register, module_power_register;
    logic [15:0] boost_period_duty_register, boost_pwm_control_register, endpoint_zero_control_register;
    logic [7:0]  descriptor_table_pointer;
    logic [1:0]  usb_config_register;
    logic [3:0]  token_register, bd_endpoint, rx_remote_endpoint;
    wire         bd_stat_valid, dplus_pullup_en, dplus_pulldown_en, dminus_pulldown_en, boost_pwm_out;
    wire         vbus_gen_active, vbus_target_sel, bd_ack, descriptor_owner_flag;
    wire  [15:0] bd_stat_data, bd_ram_addr, ep_control_used;
    wire  [5:0]  bd_index;
    wire  [3:0]  tx_remote_endpoint, last_endpoint_field;
    int          num_errors, num_checks, ones;
    uoc_row_t    rows [12];
    uoc_line_ctrl #(.PWM_W(8)) dut (.*);
    uoc_far_model u_far (.*);
    // ----------------------------------------------------------------
    // Clock, tasks and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset;
        reset_n = 1'b0;
        step(10);
        chk("outputs in reset", 16'h0000, {dplus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
            boost_pwm_out, vbus_gen_active, vbus_target_sel, bd_ack, descriptor_owner_flag, bd_index});
        chk("bd_ram_addr in reset", 16'h0000, bd_ram_addr);
        reset_n = 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #240000;
        num_errors++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {bd_req, bd_tx, bd_odd, bd_addr_word, rx_done, bus_suspended, vbus_above_target, boost_over_current} = '0;
        {usb_control_register, otg_control_register, module_power_register, boost_period_duty_register} = '0;
        {boost_pwm_control_register, endpoint_zero_control_register, usb_config_register} = '0;
        {descriptor_table_pointer, token_register, bd_endpoint, rx_remote_endpoint} = '0;
        rows = '{'{0, 1, 1, 0, 0, 3}, '{0, 15, 0, 1, 0, 30}, '{1, 0, 0, 1, 0, 1}, '{1, 0, 1, 0, 0, 2},
                 '{1, 15, 1, 0, 0, 32}, '{2, 0, 0, 0, 0, 0}, '{2, 15, 1, 1, 0, 63}, '{3, 0, 1, 1, 0, 1},
                 '{3, 1, 0, 1, 0, 3}, '{3, 15, 1, 1, 0, 61}, '{2, 9, 1, 1, 1, 3}, '{0, 7, 1, 0, 1, 1}};
        do_reset();
        chk("pull-up before vbus", 16'h0000, dplus_pullup_en);
        // Descriptor mapping rows, status reads on even rows
        descriptor_table_pointer = 8'hC4;
        endpoint_zero_control_register = 16'h001D;
        for (int i = 0; i < 12; i++) begin
            usb_config_register = rows[i].m;
            usb_control_register = {12'h000, rows[i].host, 3'h1};
            token_register = i[3:0];
            {bd_endpoint, bd_tx, bd_odd, bd_addr_word, bd_req} = {rows[i].ep, rows[i].tx, rows[i].odd, i[0], 1'b1};
            step(1);
            bd_req = 1'b0;
            chk("bd_ack", 16'h0001, bd_ack);
            chk("bd_index", rows[i].idx, bd_index);
            chk("bd_ram_addr", {8'hC4, rows[i].idx, i[0], 1'b0}, bd_ram_addr);
            if (rows[i].host) chk("ep_control_used", 16'h001D, ep_control_used);
            if (rows[i].host) chk("tx_remote_endpoint", {12'h000, i[3:0]}, tx_remote_endpoint);
            step(2);
            if (!i[0]) chk("owner flag", rows[i].idx[0], descriptor_owner_flag);
        end
        // Host receive report, then ignored while host role off
        usb_control_register = 16'h0008;
        rx_remote_endpoint = 4'hA;
        rx_done = 1'b1;
        step(1);
        usb_control_register = 16'h0000;
        rx_remote_endpoint = 4'h5;
        step(1);
        rx_done = 1'b0;
        chk("last_endpoint_field", 16'h000A, last_endpoint_field);
        // Every pull combination, suspend toggling alongside
        for (int k = 0; k < 16; k++) begin
            usb_control_register = {12'h000, k[1], 2'h0, k[0]};
            otg_control_register = {8'h00, k[3], 1'b0, k[1:0] ^ 2'h1, 1'b0, k[2], 2'h0};
            bus_suspended = k[0];
            step(1);
            chk("dplus_pullup_en", k[2] ? k[3] : k[0] & ~k[1], dplus_pullup_en);
            chk("pulldowns", k[2] ? {k[1], ~k[0]} : {2{k[1]}}, {dplus_pulldown_en, dminus_pulldown_en});
        end
        // Boost: normal, inverted, then held off by over-current
        module_power_register = 16'h0001;
        boost_period_duty_register = 16'h0204;
        for (int p = 0; p < 3; p++) begin
            boost_over_current = (p == 2);
            otg_control_register = 16'h0002;
            boost_pwm_control_register = {6'h00, p == 1, 9'h100};
            step(1);
            boost_pwm_control_register |= 16'h8000;
            step(1);
            otg_control_register |= 16'h0008;
            step(4);
            chk("vbus_gen_active", 16'h0001, vbus_gen_active);
            chk("vbus_target_sel", 16'h0001, vbus_target_sel);
            ones = 0;
            repeat (50) begin
                step(1);
                ones += boost_pwm_out;
            end
            chk("pwm high cycles", (p == 0) ? 16'd20 : (p == 1) ? 16'd30 : 16'd0, ones[15:0]);
            // Comparator at target stops switching
            vbus_above_target = 1'b1;
            ones = 0;
            repeat (10) begin
                step(1);
                ones += boost_pwm_out;
            end
            chk("pwm at target", 16'h0000, ones[15:0]);
            vbus_above_target = 1'b0;
            otg_control_register |= 16'h0001;
            step(2);
            chk("vbus_gen_active discharge", 16'h0000, vbus_gen_active);
            boost_pwm_control_register = 16'h0000;
        end
        do_reset();
        step(2);
        wrap_up();
    end
endmodule // tb_top

bind uoc_line_ctrl uoc_line_ctrl_asserts #(.PWM_W(PWM_W)) u_chk (.*);
